//--- hdl/osfd_fault_detect.sv
// Purpose: Edge or sampled level detector for one fault input.
// Assumes: pinSync is synchronous to ref_clk.
// Notes:   request is a one-cycle pulse per accepted condition.
`timescale 1ns/1ps
module osfd_fault_detect
  import osfd_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Link to the top.
  osfd_det_if.det  bus
);

  logic [6:0] divCnt_reg;
  logic       primed_reg;
  logic       lastLvl_reg;
  logic [4:0] run_reg;
  logic       fired_reg;
  logic       req_reg;

  // Decoded mode, sample tick and run arithmetic.
  wire        inLevel  = bus.pinSync ^ bus.invert;
  wire        isEdge   = (bus.mode == MODE_EDGE);
  wire        sampled  = modeSampled(bus.mode);
  wire [6:0]  divLast  = modeDivLast(bus.mode);
  wire        tick     = sampled && (divCnt_reg >= divLast);
  wire [4:0]  need     = sampleNeed(bus.count);
  wire        same     = (inLevel == lastLvl_reg);
  wire [4:0]  runNext  = !same ? 5'h01 : ((run_reg >= need) ? run_reg : run_reg + 5'h01);
  wire        edgeHit  = isEdge && primed_reg && !same;
  wire        levelHit = tick && primed_reg && (runNext >= need) && !(fired_reg && same);

  // Prescaler restarts after each sample tick.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      divCnt_reg <= 7'h00;
    else
      divCnt_reg <= (tick || !sampled) ? 7'h00 : divCnt_reg + 7'h01;
  end

  // Level history and run length; one acceptance per steady level.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      primed_reg  <= 1'b0;
      lastLvl_reg <= 1'b1;
      run_reg     <= 5'h00;
      fired_reg   <= 1'b0;
    end
    else if (isEdge || tick)
    begin
      primed_reg  <= 1'b1;
      lastLvl_reg <= inLevel;
      run_reg     <= (primed_reg && tick) ? runNext : 5'h01;
      fired_reg   <= levelHit || (fired_reg && same);
    end
  end

  // Request pulse to the top.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      req_reg <= 1'b0;
    else
      req_reg <= edgeHit || levelHit;
  end

  assign bus.request = req_reg;

endmodule

//--- hdl/osfd_top.sv
// Purpose: Output stop fault detector with an AXI4-Lite register slave.
// Assumes: Timer output and mask signals are synchronous to ref_clk and active high.
`timescale 1ns/1ps
module osfd_top
  import osfd_pkg::*;
(
  // Clock and reset.
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Fault sources.
  input  wire logic [FAULT_NUM-1:0] faultInputN,
  input  wire logic [COMP_NUM-1:0]  compOut,
  input  wire logic                 oscStop,
  // Timer outputs watched for short circuits and used as masks.
  input  wire logic [MTU_PAIRS-1:0] mtuOutHigh,
  input  wire logic [MTU_PAIRS-1:0] mtuOutLow,
  input  wire logic [GPT_PAIRS-1:0] gptOutA,
  input  wire logic [GPT_PAIRS-1:0] gptOutB,
  input  wire logic [MASK_SIGS-1:0] maskSignals,
  // Stop controls and interrupt requests.
  output logic [MTU_PAIRS-1:0]      mtuPairStop,
  output logic [GPT_PAIRS-1:0]      gptPairStop,
  output logic                      stopHighZ,
  output logic                      stopToPort,
  output logic                      irqLevelDetect,
  output logic                      irqShortDetect
);

  // Bus state.
  logic                 awready_reg;
  logic                 wready_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic [5:0]           wIdx_reg;
  logic [31:0]          wData_reg;
  logic [3:0]           wStrb_reg;
  logic                 arready_reg;
  logic                 rvalid_reg;
  logic [1:0]           rresp_reg;
  logic [31:0]          rdata_reg;

  // Configuration and flags.
  logic [8:0]           faultCfg_reg [FAULT_NUM];
  logic [FAULT_NUM-1:0] faultFlag_reg;
  logic [COMP_NUM-1:0]  compEn_reg;
  logic [COMP_NUM-1:0]  compFlag_reg;
  logic [MTU_PAIRS-1:0] mtuFlag_reg;
  logic [GPT_PAIRS-1:0] gptFlag_reg;
  logic                 mtuEn_reg;
  logic                 gptEn_reg;
  logic                 shortIrqEn_reg;
  logic                 swStop_reg;
  logic                 oscFlag_reg;
  logic                 oscEn_reg;
  logic                 hiZSel_reg;
  logic                 levelIrqEn_reg;
  logic [12:0]          maskEn_reg;
  logic [3:0]           maskSel_reg;

  // Synchronisers for pins from outside the clock domain.
  logic [FAULT_NUM-1:0] faultMeta_reg;
  logic [FAULT_NUM-1:0] faultSync_reg;
  logic [COMP_NUM-1:0]  compMeta_reg;
  logic [COMP_NUM-1:0]  compSync_reg;
  logic                 oscMeta_reg;
  logic                 oscSync_reg;

  // Output flops.
  logic [MTU_PAIRS-1:0] mtuPairStop_reg;
  logic [GPT_PAIRS-1:0] gptPairStop_reg;
  logic                 stopHighZ_reg;
  logic                 stopToPort_reg;
  logic                 irqLevel_reg;
  logic                 irqShort_reg;

  logic [FAULT_NUM-1:0] detReq;
  logic [FAULT_NUM-1:0] faultSampled;

  // Two flops on every asynchronous input.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      faultMeta_reg <= '1;
      faultSync_reg <= '1;
      compMeta_reg  <= '0;
      compSync_reg  <= '0;
      oscMeta_reg   <= 1'b0;
      oscSync_reg   <= 1'b0;
    end
    else
    begin
      faultMeta_reg <= faultInputN;
      faultSync_reg <= faultMeta_reg;
      compMeta_reg  <= compOut;
      compSync_reg  <= compMeta_reg;
      oscMeta_reg   <= oscStop;
      oscSync_reg   <= oscMeta_reg;
    end
  end

  // One detector per fault input.
  for (genvar i = 0; i < FAULT_NUM; i++)
  begin : gDet
    osfd_det_if detBus ();
    assign detBus.mode    = faultCfg_reg[i][FC_MODE_LSB +: 4];
    assign detBus.count   = faultCfg_reg[i][FC_COUNT_LSB +: 4];
    assign detBus.invert  = faultCfg_reg[i][FC_INV_BIT];
    assign detBus.pinSync = faultSync_reg[i];
    assign detReq[i]      = detBus.request;
    assign faultSampled[i] = modeSampled(faultCfg_reg[i][FC_MODE_LSB +: 4]);
    osfd_fault_detect uDet (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .bus     (detBus)
    );
  end

  // Write decode with byte strobes applied.
  wire        doWrite  = !awready_reg && !wready_reg && !bvalid_reg;
  wire [31:0] strbMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
                          {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
  wire [31:0] wBits    = wData_reg & strbMask;
  wire        wMapped  = (wIdx_reg <= IDX_MASK);
  wire        wFault   = doWrite && (wIdx_reg < IDX_COMP);
  wire        wComp    = doWrite && (wIdx_reg == IDX_COMP);
  wire        wShort   = doWrite && (wIdx_reg == IDX_SHORT);
  wire        wStop    = doWrite && (wIdx_reg == IDX_STOP);
  wire        wMask    = doWrite && (wIdx_reg == IDX_MASK);

  // Flag sources; masking applies only to level and comparator requests.
  wire        maskLevel = maskSignals[maskSel_reg];
  wire [FAULT_NUM-1:0] faultMasked = maskEn_reg[FAULT_NUM-1:0] & faultSampled
                                     & {FAULT_NUM{maskLevel}};
  wire [COMP_NUM-1:0]  compMasked  = maskEn_reg[12:FAULT_NUM] & {COMP_NUM{maskLevel}};
  wire [FAULT_NUM-1:0] faultSet = detReq & ~faultMasked;
  wire [COMP_NUM-1:0]  compSet  = compSync_reg & compEn_reg & ~compMasked;
  wire [MTU_PAIRS-1:0] mtuSet   = mtuOutHigh & mtuOutLow & {MTU_PAIRS{mtuEn_reg}};
  wire [GPT_PAIRS-1:0] gptSet   = gptOutA & gptOutB & {GPT_PAIRS{gptEn_reg}};
  wire                 oscSet   = oscSync_reg && oscEn_reg;

  // Clear masks from write-one-to-clear bits.
  wire [COMP_NUM-1:0]  compClr  = wComp ? wBits[CP_FLAG_LSB +: COMP_NUM] : '0;
  wire [MTU_PAIRS-1:0] mtuClr   = wShort ? wBits[SC_MTU_LSB +: MTU_PAIRS] : '0;
  wire [GPT_PAIRS-1:0] gptClr   = wShort ? wBits[SC_GPT_LSB +: GPT_PAIRS] : '0;
  wire                 oscClr   = wStop && wBits[ST_OSC_BIT];
  wire                 allStop  = (|faultFlag_reg) || (|compFlag_reg) || oscFlag_reg
                                  || swStop_reg;

  // Fault input configuration words and their sticky flags.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < FAULT_NUM; i++)
        faultCfg_reg[i] <= FC_CFG_RESET;
      faultFlag_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < FAULT_NUM; i++)
      begin
        if (wFault && (wIdx_reg == 6'(i)))
          faultCfg_reg[i] <= (faultCfg_reg[i] & ~strbMask[8:0]) | wBits[8:0];
        faultFlag_reg[i] <= faultSet[i] || (faultFlag_reg[i]
          && !(wFault && (wIdx_reg == 6'(i)) && wBits[FC_FLAG_BIT]));
      end
    end
  end

  // Comparator and short circuit controls with sticky flags.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      compEn_reg     <= '0;
      compFlag_reg   <= '0;
      mtuFlag_reg    <= '0;
      gptFlag_reg    <= '0;
      mtuEn_reg      <= 1'b0;
      gptEn_reg      <= 1'b0;
      shortIrqEn_reg <= 1'b0;
    end
    else
    begin
      if (wComp)
        compEn_reg <= (compEn_reg & ~strbMask[COMP_NUM-1:0]) | wBits[COMP_NUM-1:0];
      if (wShort && strbMask[SC_MTU_EN_BIT])
      begin
        mtuEn_reg      <= wBits[SC_MTU_EN_BIT];
        gptEn_reg      <= wBits[SC_GPT_EN_BIT];
        shortIrqEn_reg <= wBits[SC_IRQ_EN_BIT];
      end
      compFlag_reg <= compSet | (compFlag_reg & ~compClr);
      mtuFlag_reg  <= mtuSet | (mtuFlag_reg & ~mtuClr);
      gptFlag_reg  <= gptSet | (gptFlag_reg & ~gptClr);
    end
  end

  // Software stop, oscillator flag, pin state select and mask selection.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      swStop_reg     <= 1'b0;
      oscFlag_reg    <= 1'b0;
      oscEn_reg      <= ST_OSCEN_RESET;
      hiZSel_reg     <= 1'b0;
      levelIrqEn_reg <= 1'b0;
      maskEn_reg     <= '0;
      maskSel_reg    <= 4'h0;
    end
    else
    begin
      if (wStop && strbMask[ST_SW_BIT])
      begin
        swStop_reg     <= wBits[ST_SW_BIT];
        hiZSel_reg     <= wBits[ST_HIZ_BIT];
        levelIrqEn_reg <= wBits[ST_LIRQ_BIT];
        oscEn_reg      <= wBits[ST_OSCEN_BIT];
      end
      oscFlag_reg <= oscSet || (oscFlag_reg && !oscClr);
      if (wMask)
      begin
        maskEn_reg  <= (maskEn_reg & ~strbMask[12:0]) | wBits[12:0];
        if (strbMask[MK_SEL_LSB])
          maskSel_reg <= wBits[MK_SEL_LSB +: 4];
      end
    end
  end

  // Stop outputs and interrupt requests, all registered.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mtuPairStop_reg <= '0;
      gptPairStop_reg <= '0;
      stopHighZ_reg   <= 1'b0;
      stopToPort_reg  <= 1'b0;
      irqLevel_reg    <= 1'b0;
      irqShort_reg    <= 1'b0;
    end
    else
    begin
      mtuPairStop_reg <= {MTU_PAIRS{allStop}} | mtuFlag_reg;
      gptPairStop_reg <= {GPT_PAIRS{allStop}} | gptFlag_reg;
      stopHighZ_reg   <= (allStop || (|mtuFlag_reg) || (|gptFlag_reg)) && hiZSel_reg;
      stopToPort_reg  <= (allStop || (|mtuFlag_reg) || (|gptFlag_reg)) && !hiZSel_reg;
      irqLevel_reg    <= levelIrqEn_reg && (|(faultFlag_reg & faultSampled));
      irqShort_reg    <= shortIrqEn_reg && ((|mtuFlag_reg) || (|gptFlag_reg));
    end
  end

  // Write channel handshake: address and data taken in either order.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      wIdx_reg    <= 6'h00;
      wData_reg   <= 32'h00000000;
      wStrb_reg   <= 4'h0;
    end
    else
    begin
      if (awready_reg && s_axi_awvalid)
      begin
        awready_reg <= 1'b0;
        wIdx_reg    <= s_axi_awaddr[7:2];
      end
      if (wready_reg && s_axi_wvalid)
      begin
        wready_reg <= 1'b0;
        wData_reg  <= s_axi_wdata;
        wStrb_reg  <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Read selection.
  wire [5:0]  rIdx      = s_axi_araddr[7:2];
  wire [2:0]  rFaultIdx = rIdx[2:0];
  wire [31:0] faultWord = {19'h0, faultFlag_reg[rFaultIdx], 3'h0, faultCfg_reg[rFaultIdx]};
  wire [31:0] compWord  = {18'h0, compFlag_reg, 2'h0, compEn_reg};
  wire [31:0] shortWord = {13'h0, shortIrqEn_reg, gptEn_reg, mtuEn_reg, 1'b0, gptFlag_reg,
                           2'h0, mtuFlag_reg};
  wire [31:0] stopWord  = {23'h0, allStop, 3'h0, oscEn_reg, levelIrqEn_reg, hiZSel_reg,
                           oscFlag_reg, swStop_reg};
  wire [31:0] maskWord  = {12'h0, maskSel_reg, 3'h0, maskEn_reg};
  wire        rMapped   = (rIdx <= IDX_MASK);
  wire [31:0] readWord  = (rIdx < IDX_COMP)  ? faultWord :
                          (rIdx == IDX_COMP)  ? compWord  :
                          (rIdx == IDX_SHORT) ? shortWord :
                          (rIdx == IDX_STOP)  ? stopWord  :
                          (rIdx == IDX_MASK)  ? maskWord  : 32'h00000000;

  // Read channel handshake: data one cycle after the address is taken.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end
    else if (arready_reg && s_axi_arvalid)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= readWord;
      rresp_reg   <= rMapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // Port drivers.
  assign s_axi_awready  = awready_reg;
  assign s_axi_wready   = wready_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = arready_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rresp    = rresp_reg;
  assign s_axi_rdata    = rdata_reg;
  assign mtuPairStop    = mtuPairStop_reg;
  assign gptPairStop    = gptPairStop_reg;
  assign stopHighZ      = stopHighZ_reg;
  assign stopToPort     = stopToPort_reg;
  assign irqLevelDetect = irqLevel_reg;
  assign irqShortDetect = irqShort_reg;

endmodule

//--- shared/osfd_det_if.sv
// Purpose: Carries configuration and the request pulse between top and one detector.
// Assumes: Both ends run on ref_clk.
// Notes:   pinSync is already synchronised by the top.
`timescale 1ns/1ps
interface osfd_det_if;
  logic [3:0] mode;
  logic [3:0] count;
  logic       invert;
  logic       pinSync;
  logic       request;
  modport ctl (output mode, count, invert, pinSync, input request);
  modport det (input mode, count, invert, pinSync, output request);
endinterface

//--- shared/osfd_pkg.sv
// Purpose: Shared constants, register map and helper functions of the output stop block.
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
// Notes:   Fault input index 0..6 stands for fault inputs a..g.
package osfd_pkg;

  // Sizes of the watched source groups.
  localparam int FAULT_NUM = 7;
  localparam int COMP_NUM  = 6;
  localparam int MTU_PAIRS = 6;
  localparam int GPT_PAIRS = 7;
  localparam int MASK_SIGS = 16;

  // Register word indices (byte address is four times the index).
  localparam logic [5:0] IDX_FAULT_BASE = 6'h00;
  localparam logic [5:0] IDX_COMP       = 6'h07;
  localparam logic [5:0] IDX_SHORT      = 6'h08;
  localparam logic [5:0] IDX_STOP       = 6'h09;
  localparam logic [5:0] IDX_MASK       = 6'h0A;

  // Fault input control word fields.
  localparam int FC_MODE_LSB  = 0;
  localparam int FC_COUNT_LSB = 4;
  localparam int FC_INV_BIT   = 8;
  localparam int FC_FLAG_BIT  = 12;
  localparam logic [8:0] FC_CFG_RESET = 9'h000;

  // Comparator word fields.
  localparam int CP_EN_LSB   = 0;
  localparam int CP_FLAG_LSB = 8;

  // Short circuit word fields.
  localparam int SC_MTU_LSB    = 0;
  localparam int SC_GPT_LSB    = 8;
  localparam int SC_MTU_EN_BIT = 16;
  localparam int SC_GPT_EN_BIT = 17;
  localparam int SC_IRQ_EN_BIT = 18;

  // Stop control word fields.
  localparam int ST_SW_BIT     = 0;
  localparam int ST_OSC_BIT    = 1;
  localparam int ST_HIZ_BIT    = 2;
  localparam int ST_LIRQ_BIT   = 3;
  localparam int ST_OSCEN_BIT  = 4;
  localparam int ST_ACTIVE_BIT = 8;
  localparam logic ST_OSCEN_RESET = 1'b1;

  // Mask word fields.
  localparam int MK_EN_LSB  = 0;
  localparam int MK_SEL_LSB = 16;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Detection mode codes.
  localparam logic [3:0] MODE_EDGE   = 4'h0;
  localparam logic [3:0] MODE_DIV8   = 4'h1;
  localparam logic [3:0] MODE_DIV16  = 4'h2;
  localparam logic [3:0] MODE_DIV128 = 4'h3;
  localparam logic [3:0] MODE_DIV1   = 4'h4;
  localparam logic [3:0] MODE_DIV2   = 4'h5;
  localparam logic [3:0] MODE_DIV4   = 4'h6;

  // Sample clock dividers, as terminal counts of the prescaler.
  localparam logic [6:0] DIV8_LAST   = 7'h07;
  localparam logic [6:0] DIV16_LAST  = 7'h0F;
  localparam logic [6:0] DIV128_LAST = 7'h7F;
  localparam logic [6:0] DIV1_LAST   = 7'h00;
  localparam logic [6:0] DIV2_LAST   = 7'h01;
  localparam logic [6:0] DIV4_LAST   = 7'h03;

  // Sample count figures.
  localparam logic [4:0] NEED_16     = 5'h10;
  localparam logic [4:0] NEED_4      = 5'h04;
  localparam logic [4:0] NEED_8      = 5'h08;
  localparam logic [4:0] NEED_OFFSET = 5'h06;

  // Terminal prescaler count for a sampled mode.
  function automatic logic [6:0] modeDivLast(input logic [3:0] mode);
    unique case (mode)
      MODE_DIV8:   modeDivLast = DIV8_LAST;
      MODE_DIV16:  modeDivLast = DIV16_LAST;
      MODE_DIV128: modeDivLast = DIV128_LAST;
      MODE_DIV2:   modeDivLast = DIV2_LAST;
      MODE_DIV4:   modeDivLast = DIV4_LAST;
      default:     modeDivLast = DIV1_LAST;
    endcase
  endfunction

  // True for a sampled mode code that is defined.
  function automatic logic modeSampled(input logic [3:0] mode);
    modeSampled = (mode >= MODE_DIV8) && (mode <= MODE_DIV4);
  endfunction

  // Consecutive samples required for a count code; undefined codes act as 16.
  function automatic logic [4:0] sampleNeed(input logic [3:0] code);
    if (code == 4'h1)
      sampleNeed = NEED_4;
    else if (code == 4'h2)
      sampleNeed = NEED_8;
    else if (code >= 4'h3 && code <= 4'h9)
      sampleNeed = {1'b0, code} + NEED_OFFSET;
    else
      sampleNeed = NEED_16;
  endfunction

endpackage

//--- sim/osfd_partner.sv
// Purpose: Far-side model of the fault pins and timer output pairs.
// Assumes: Bench commands change just after a rising edge.
// Notes: Fault pins idle high through their pull-ups.
`timescale 1ns/1ps
module osfd_partner
(
  // Clock and commands.
  input  wire logic       ref_clk,
  input  wire logic [6:0] pinLow,
  input  wire logic       shortReq,
  // Pins toward the block.
  output logic [6:0] faultInputN,
  output logic [5:0] mtuOutHigh,
  output logic [5:0] mtuOutLow,
  output logic [6:0] gptOutA,
  output logic [6:0] gptOutB
);
  logic phase = 1'b0;
  // Phases swap every cycle.
  always @(posedge ref_clk)
    phase <= ~phase;
  // Pairs overlap only while a short is commanded.
  assign mtuOutHigh  = {6{phase | shortReq}};
  assign mtuOutLow   = {6{~phase | shortReq}};
  assign gptOutA     = {7{phase | shortReq}};
  assign gptOutB     = {7{~phase | shortReq}};
  assign faultInputN = ~pinLow;
endmodule

//--- sim/osfd_tb.sv
// Purpose: Self-checking bench for the output stop block.
// Assumes: Registers reached by AXI4-Lite tasks.
// Notes: Strobes stay full; bready and rready stay high so calls never clash.
`timescale 1ns/1ps
module osfd_tb
  import osfd_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} osfd_row_t;
  logic ref_clk = 0, resetn = 0, shortReq = 0, oscStop = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, rdv, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [6:0] pinLow = '0, faultInputN, gptOutA, gptOutB, gptPairStop;
  logic [5:0] compOut = '0, mtuOutHigh, mtuOutLow, mtuPairStop;
  logic [15:0] maskSignals = '0;
  logic [1:0] rsp, wrsp, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic stopHighZ, stopToPort, irqLevelDetect, irqShortDetect;
  int fails = 0, n_compared = 0, cyc = 0;
  osfd_row_t rows [5] = '{'{8'h24, 32'h11, 32'h111, RESP_OKAY},
    '{8'h24, 32'h10, 32'h10, RESP_OKAY}, '{8'h18, 32'h197, 32'h197, RESP_OKAY},
    '{8'h28, 32'hF1FFF, 32'hF1FFF, RESP_OKAY}, '{8'h2C, 32'h5, 32'h0, RESP_SLVERR}};
  osfd_top uut (.*);
  osfd_partner u_partner (.*);
  always #12.5 ref_clk = ~ref_clk;
  // Cuts a hang short.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    wrsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(8'h24);
    chk("stopReg", rdv, 32'h10);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("rowData", rdv, rows[i].e);
      chk("rowResp", rsp, rows[i].r);
      chk("rowWResp", wrsp, rows[i].r);
    end
    $display("rows done");
    wr(8'h20, 32'h70000);
    shortReq <= 1'b1;
    @(posedge ref_clk);
    shortReq <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("mtuStop", mtuPairStop, 6'h3F);
    chk("gptStop", gptPairStop, 7'h7F);
    chk("irqShort", irqShortDetect, 1'h1);
    wr(8'h24, 32'h14);
    @(posedge ref_clk);
    chk("highZ", {stopHighZ, stopToPort}, 2'h2);
    wr(8'h20, 32'h77F3F);
    rd(8'h20);
    chk("shortReg", rdv, 32'h70000);
    chk("mtuClear", mtuPairStop, 6'h0);
    chk("gptClear", gptPairStop, 7'h0);
    $display("short done");
    wr(8'h24, 32'h18);
    wr(8'h00, 32'h14);
    repeat (20) @(posedge ref_clk);
    rd(8'h00);
    chk("highRun", rdv, 32'h1014);
    chk("irqLevel", irqLevelDetect, 1'h1);
    chk("toPort", stopToPort, 1'h1);
    wr(8'h00, 32'h1014);
    rd(8'h00);
    chk("steady", rdv, 32'h14);
    pinLow[0] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rd(8'h00);
    chk("lowRun", rdv, 32'h1014);
    pinLow[1] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(8'h04);
    chk("edgeFall", rdv, 32'h1000);
    wr(8'h1C, 32'h1);
    maskSignals[15] <= 1'b1;
    compOut[0] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(8'h1C);
    chk("compMasked", rdv, 32'h1);
    maskSignals[15] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd(8'h1C);
    chk("compFlag", rdv, 32'h101);
    oscStop <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(8'h24);
    chk("oscFlag", rdv, 32'h11A);
    $display("level, edge, comparator and mask done");
    resetn <= 1'b0;
    pinLow <= '0;
    compOut <= '0;
    oscStop <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("rstOut", {mtuPairStop, stopToPort, irqLevelDetect}, 32'h0);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(8'h24);
    chk("rstStop", rdv, 32'h10);
    rd(8'h00);
    chk("rstFault", rdv, 32'h0);
    $display("reset done");
    conclude();
  end
endmodule

//--- sim/osfd_top_chk.sv
// Purpose: Port-level assertions of the output stop block.
// Assumes: One clock domain.
// Notes: Attached by bind.
`timescale 1ns/1ps
module osfd_chk
  import osfd_pkg::*;
(
  // Clock, reset and bus.
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Stop and interrupt outputs.
  input wire logic [MTU_PAIRS-1:0] mtuPairStop,
  input wire logic [GPT_PAIRS-1:0] gptPairStop,
  input wire logic stopHighZ,
  input wire logic stopToPort,
  input wire logic irqLevelDetect,
  input wire logic irqShortDetect
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Bus answers stand until taken.
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while pending");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while pending");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready) else $error("write not closed");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read not closed");
  // Stop state and its causes.
  a_stop_mode: assert property (stopHighZ |-> !stopToPort)
    else $error("both stop modes");
  a_short_stops: assert property (irqShortDetect [*2]
    |-> (|mtuPairStop) || (|gptPairStop)) else $error("short without stop");
  a_level_stops: assert property (irqLevelDetect [*2]
    |-> stopHighZ || stopToPort) else $error("level without stop");
  c_short: cover property (|mtuPairStop);
  c_level: cover property (irqLevelDetect);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind osfd_top osfd_chk u_chk (.*);
